/* logic/ipcb_pkg.sv */
// Constants for the interrupt priority configuration bank.
// Assumes one 100 MHz system clock and a plain register port.
package ipcb_pkg;

	// Bus and bank sizes.
	localparam int IPCB_DATA_W  = 16;
	localparam int IPCB_ADDR_W  = 4;
	localparam int IPCB_FIELD_W = 2;
	localparam int IPCB_NUM_SRC = 15;
	localparam int IPCB_NUM_DBG = 5;

	// Register offsets in words.
	localparam logic [3:0] IPCB_OFF_DEBUG_EVENT = 4'h0;
	localparam logic [3:0] IPCB_OFF_DEBUG_COMM  = 4'h1;
	localparam logic [3:0] IPCB_OFF_SYSTEM      = 4'h2;
	localparam logic [3:0] IPCB_OFF_CAN         = 4'h3;

	// Implemented bits of each register; all other bits are reserved.
	localparam logic [15:0] IPCB_MASK_DEBUG_EVENT = 16'h3C00;
	localparam logic [15:0] IPCB_MASK_DEBUG_COMM  = 16'h003F;
	localparam logic [15:0] IPCB_MASK_SYSTEM      = 16'hFFC3;
	localparam logic [15:0] IPCB_MASK_CAN         = 16'h03FC;
	localparam logic [15:0] IPCB_RESET_PRIO       = 16'h0000;
	localparam logic [15:0] IPCB_READ_NONE        = 16'h0000;

	// Field positions (low bit of each two-bit field).
	localparam int IPCB_LSB_BREAKPOINT0 = 12;
	localparam int IPCB_LSB_STEP_COUNT  = 10;
	localparam int IPCB_LSB_DBG_RX_FULL = 4;
	localparam int IPCB_LSB_DBG_TX_EMPT = 2;
	localparam int IPCB_LSB_TRACE_BUF   = 0;
	localparam int IPCB_LSB_FLASH_BUFS  = 14;
	localparam int IPCB_LSB_FLASH_DONE  = 12;
	localparam int IPCB_LSB_FLASH_FAULT = 10;
	localparam int IPCB_LSB_PLL_SLIP    = 8;
	localparam int IPCB_LSB_UNDERVOLT   = 6;
	localparam int IPCB_LSB_EXT_LINE_A  = 0;
	localparam int IPCB_LSB_CAN_MAILBOX = 8;
	localparam int IPCB_LSB_CAN_WAKE    = 6;
	localparam int IPCB_LSB_CAN_FAULT   = 4;
	localparam int IPCB_LSB_CAN_BUSOFF  = 2;

	// Field encodings.
	localparam logic [1:0] IPCB_CODE_OFF   = 2'h0;
	localparam logic [1:0] IPCB_LEVEL_STEP = 2'h1;

	typedef logic [1:0] ipcb_level_t;

endpackage

/* logic/ipcb_level_decode.sv */
// Decodes one two-bit priority field into a request and a level.
// Assumes the request input is already on the system clock.
`timescale 1ns/10ps
`default_nettype none
module ipcb_level_decode
	import ipcb_pkg::*;
#(
	parameter bit IS_DEBUG = 1'b0
) (
	input  wire ipcb_level_t code,
	input  wire logic        request,
	output logic             reqValid,
	output ipcb_level_t      reqLevel
);

	// A zero field disables the source; nonzero fields pass it on.
	assign reqValid = request && (code != IPCB_CODE_OFF);

	// Debug sources map codes to levels 1..3, all others to levels 0..2.
	assign reqLevel = IS_DEBUG ? code : ipcb_level_t'(code - IPCB_LEVEL_STEP);

endmodule
`default_nettype wire

/* logic/ipcb_priority_bank.sv */
// Interrupt priority configuration bank: four priority registers and
// the per-source enable and level passed on to the arbitration logic.
// Assumes the register port and all source requests run on clk_sys.
//
// Summary of operation
// R1 - Reserved bits read zero and ignore writes.
// R2 - Debug fields: 00 off, 01..11 give levels 1..3.
// R3 - Other fields: 00 off, 01..11 give levels 0..2.
// R4 - Reset clears every field, so all sources start disabled.
// R5 - Offset 0 bits 13:12 hold the breakpoint unit 0 field.
// R6 - Offset 0 bits 11:10 hold the step counter field.
// R7 - Offset 1 bits 5:4 hold the debug receive-full field.
// R8 - Offset 1 bits 3:2 hold the debug transmit-empty field.
// R9 - Offset 1 bits 1:0 hold the trace buffer field.
// R10 - Offset 2 bits 15:14 hold the flash buffers-empty field.
// R11 - Offset 2 bits 13:12 hold the flash command-complete field.
// R12 - Offset 2 bits 11:10 hold the flash error field.
// R13 - Offset 2 bits 9:8 hold the PLL loss-of-lock field.
// R14 - Offset 2 bits 7:6 hold the low-voltage detector field.
// R15 - Offset 2 bits 1:0 hold the external line A field.
// R16 - Offset 3 bits 9:8 hold the CAN mailbox field.
// R17 - Offset 3 bits 7:6 hold the CAN wake-up field.
// R18 - Offset 3 bits 5:4 hold the CAN error field.
// R19 - Offset 3 bits 3:2 hold the CAN bus-off field.
// R20 - Requests pass only while their field is nonzero, with decoded level.
`timescale 1ns/10ps
`default_nettype none
module ipcb_priority_bank
	import ipcb_pkg::*;
(
	input  wire logic                      clk_sys,
	input  wire logic                      rst,
	input  wire logic [IPCB_ADDR_W-1:0]    regAddr,
	input  wire logic [IPCB_DATA_W-1:0]    regWrData,
	input  wire logic                      regWrStb,
	input  wire logic                      regRdStb,
	output logic      [IPCB_DATA_W-1:0]    regRdData,
	input  wire logic [IPCB_NUM_SRC-1:0]   srcRequest,
	output logic      [IPCB_NUM_SRC-1:0]   arbValid,
	output logic      [2*IPCB_NUM_SRC-1:0] arbLevel
);

	logic [IPCB_DATA_W-1:0]    debugEventPriorityA;
	logic [IPCB_DATA_W-1:0]    debugCommPriority;
	logic [IPCB_DATA_W-1:0]    systemEventPriority;
	logic [IPCB_DATA_W-1:0]    canEventPriority;
	ipcb_level_t               fieldCode [IPCB_NUM_SRC];
	logic [IPCB_NUM_SRC-1:0]   next_arbValid;
	logic [2*IPCB_NUM_SRC-1:0] next_arbLevel;
	logic [IPCB_NUM_SRC-1:0]   codeNonzero;

	// Register writes; only implemented bits are stored.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			debugEventPriorityA <= IPCB_RESET_PRIO; // R4
			debugCommPriority   <= IPCB_RESET_PRIO;
			systemEventPriority <= IPCB_RESET_PRIO;
			canEventPriority    <= IPCB_RESET_PRIO;
		end else if (regWrStb) begin
			if (regAddr == IPCB_OFF_DEBUG_EVENT) begin
				debugEventPriorityA <= regWrData & IPCB_MASK_DEBUG_EVENT; // R1
			end else if (regAddr == IPCB_OFF_DEBUG_COMM) begin
				debugCommPriority <= regWrData & IPCB_MASK_DEBUG_COMM; // R1
			end else if (regAddr == IPCB_OFF_SYSTEM) begin
				systemEventPriority <= regWrData & IPCB_MASK_SYSTEM; // R1
			end else if (regAddr == IPCB_OFF_CAN) begin
				canEventPriority <= regWrData & IPCB_MASK_CAN; // R1
			end
		end
	end

	// Read data stands only in the cycle after the read strobe.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			regRdData <= IPCB_READ_NONE;
		end else if (regRdStb) begin
			if (regAddr == IPCB_OFF_DEBUG_EVENT) begin
				regRdData <= debugEventPriorityA & IPCB_MASK_DEBUG_EVENT; // R1
			end else if (regAddr == IPCB_OFF_DEBUG_COMM) begin
				regRdData <= debugCommPriority & IPCB_MASK_DEBUG_COMM;
			end else if (regAddr == IPCB_OFF_SYSTEM) begin
				regRdData <= systemEventPriority & IPCB_MASK_SYSTEM;
			end else if (regAddr == IPCB_OFF_CAN) begin
				regRdData <= canEventPriority & IPCB_MASK_CAN;
			end else begin
				regRdData <= IPCB_READ_NONE;
			end
		end else begin
			regRdData <= IPCB_READ_NONE;
		end
	end

	// Field extraction, one source per line, debug sources first.
	assign fieldCode[0]  = debugEventPriorityA[IPCB_LSB_BREAKPOINT0 +: IPCB_FIELD_W]; // R5
	assign fieldCode[1]  = debugEventPriorityA[IPCB_LSB_STEP_COUNT +: IPCB_FIELD_W]; // R6
	assign fieldCode[2]  = debugCommPriority[IPCB_LSB_DBG_RX_FULL +: IPCB_FIELD_W]; // R7
	assign fieldCode[3]  = debugCommPriority[IPCB_LSB_DBG_TX_EMPT +: IPCB_FIELD_W]; // R8
	assign fieldCode[4]  = debugCommPriority[IPCB_LSB_TRACE_BUF +: IPCB_FIELD_W]; // R9
	assign fieldCode[5]  = systemEventPriority[IPCB_LSB_FLASH_BUFS +: IPCB_FIELD_W]; // R10
	assign fieldCode[6]  = systemEventPriority[IPCB_LSB_FLASH_DONE +: IPCB_FIELD_W]; // R11
	assign fieldCode[7]  = systemEventPriority[IPCB_LSB_FLASH_FAULT +: IPCB_FIELD_W]; // R12
	assign fieldCode[8]  = systemEventPriority[IPCB_LSB_PLL_SLIP +: IPCB_FIELD_W]; // R13
	assign fieldCode[9]  = systemEventPriority[IPCB_LSB_UNDERVOLT +: IPCB_FIELD_W]; // R14
	assign fieldCode[10] = systemEventPriority[IPCB_LSB_EXT_LINE_A +: IPCB_FIELD_W]; // R15
	assign fieldCode[11] = canEventPriority[IPCB_LSB_CAN_MAILBOX +: IPCB_FIELD_W]; // R16
	assign fieldCode[12] = canEventPriority[IPCB_LSB_CAN_WAKE +: IPCB_FIELD_W]; // R17
	assign fieldCode[13] = canEventPriority[IPCB_LSB_CAN_FAULT +: IPCB_FIELD_W]; // R18
	assign fieldCode[14] = canEventPriority[IPCB_LSB_CAN_BUSOFF +: IPCB_FIELD_W]; // R19

	// One decoder per source; the first sources use the debug encoding.
	genvar gi;
	generate
		for (gi = 0; gi < IPCB_NUM_SRC; gi++) begin : g_src
			ipcb_level_decode #(
				.IS_DEBUG (gi < IPCB_NUM_DBG) // R2 R3
			) u_dec (
				.code     (fieldCode[gi]),
				.request  (srcRequest[gi]),
				.reqValid (next_arbValid[gi]),
				.reqLevel (next_arbLevel[2*gi +: 2])
			);
			assign codeNonzero[gi] = (fieldCode[gi] != IPCB_CODE_OFF);
		end
	endgenerate

	// Requests to the arbiter are registered so they change on clock edges.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			arbValid <= '0;
			arbLevel <= '0;
		end else begin
			arbValid <= next_arbValid; // R20
			arbLevel <= next_arbLevel;
		end
	end

	// Helper state for the checks: the address and read strobe of the previous cycle.
	logic [IPCB_ADDR_W-1:0] rdAddrQ;
	logic                   rdPend;
	logic [IPCB_DATA_W-1:0] rdMaskQ;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdAddrQ <= '0;
			rdPend  <= 1'b0;
		end else begin
			rdAddrQ <= regAddr;
			rdPend  <= regRdStb;
		end
	end

	// Mask of implemented bits for the previously read address.
	always_comb begin
		if (rdAddrQ == IPCB_OFF_DEBUG_EVENT) begin
			rdMaskQ = IPCB_MASK_DEBUG_EVENT;
		end else if (rdAddrQ == IPCB_OFF_DEBUG_COMM) begin
			rdMaskQ = IPCB_MASK_DEBUG_COMM;
		end else if (rdAddrQ == IPCB_OFF_SYSTEM) begin
			rdMaskQ = IPCB_MASK_SYSTEM;
		end else if (rdAddrQ == IPCB_OFF_CAN) begin
			rdMaskQ = IPCB_MASK_CAN;
		end else begin
			rdMaskQ = IPCB_READ_NONE;
		end
	end

	// Reserved and unmapped bits never appear on a read.
	a_reserved_read_zero: assert property ( // R1
		@(posedge clk_sys) disable iff (rst)
		rdPend |-> ((regRdData & ~rdMaskQ) == IPCB_READ_NONE)
	) else $error("Reserved bit read back as one.");

	// Writing all ones to offset 2 then reading it returns just the implemented bits.
	a_reserved_write_drop: assert property ( // R1
		@(posedge clk_sys) disable iff (rst)
		(regWrStb && regAddr == IPCB_OFF_SYSTEM && regWrData == 16'hFFFF)
		##1 (regRdStb && regAddr == IPCB_OFF_SYSTEM && !regWrStb)
		|=> (regRdData == IPCB_MASK_SYSTEM)
	) else $error("Reserved bits took a written value.");

	// Read data stands for one cycle only.
	a_read_one_cycle: assert property (
		@(posedge clk_sys) disable iff (rst)
		!regRdStb |=> (regRdData == IPCB_READ_NONE)
	) else $error("Read data outlived its cycle.");

	// Reset leaves every source disabled and quiet.
	a_reset_disables: assert property ( // R4
		@(posedge clk_sys)
		rst |=> (codeNonzero == '0) && (arbValid == '0) && (arbLevel == '0)
	) else $error("A source is enabled right after reset.");

	// A request reaches the arbiter exactly when enabled and raised.
	a_request_gating: assert property ( // R20
		@(posedge clk_sys) disable iff (rst)
		##1 (arbValid == $past(codeNonzero & srcRequest))
	) else $error("Request gating disagrees with field enables.");

	// Debug breakpoint field decodes straight to level 1..3.
	a_debug_level_map: assert property ( // R2
		@(posedge clk_sys) disable iff (rst)
		(fieldCode[0] != IPCB_CODE_OFF && srcRequest[0])
		|=> arbValid[0] && (arbLevel[1:0] == $past(fieldCode[0]))
	) else $error("Debug source level is wrong.");

	// Flash error field decodes to one level below its code.
	a_system_level_map: assert property ( // R3
		@(posedge clk_sys) disable iff (rst)
		(fieldCode[7] != IPCB_CODE_OFF && srcRequest[7])
		|=> arbValid[7] && (arbLevel[15:14] == 2'($past(fieldCode[7]) - 2'h1))
	) else $error("System source level is wrong.");

	// Top code of a non-debug source gives level 2, never 3.
	a_no_level_three: assert property ( // R3
		@(posedge clk_sys) disable iff (rst)
		(fieldCode[14] == 2'h3 && srcRequest[14])
		|=> (arbLevel[29:28] == 2'h2)
	) else $error("Non-debug source reached level 3.");

	// Step counter field follows a write to offset 0.
	a_step_field_write: assert property ( // R6
		@(posedge clk_sys) disable iff (rst)
		(regWrStb && regAddr == IPCB_OFF_DEBUG_EVENT)
		|=> (fieldCode[1] == $past(regWrData[11:10]))
	) else $error("Step counter field missed a write.");

	// Breakpoint field follows a write to offset 0.
	a_bkpt_field_write: assert property ( // R5
		@(posedge clk_sys) disable iff (rst)
		(regWrStb && regAddr == IPCB_OFF_DEBUG_EVENT)
		|=> (fieldCode[0] == $past(regWrData[13:12]))
	) else $error("Breakpoint field missed a write.");

	// Debug receive-full field follows a write to offset 1.
	a_rx_field_write: assert property ( // R7
		@(posedge clk_sys) disable iff (rst)
		(regWrStb && regAddr == IPCB_OFF_DEBUG_COMM)
		|=> (fieldCode[2] == $past(regWrData[5:4]))
	) else $error("Receive-full field missed a write.");

	// PLL field follows a write to offset 2 and holds without writes.
	a_pll_field_write: assert property ( // R13
		@(posedge clk_sys) disable iff (rst)
		(regWrStb && regAddr == IPCB_OFF_SYSTEM) ##1 !regWrStb
		|=> (fieldCode[8] == $past(regWrData[9:8], 2))
	) else $error("PLL field missed a write or changed alone.");

	// External line A field follows a write to offset 2.
	a_ext_a_field_write: assert property ( // R15
		@(posedge clk_sys) disable iff (rst)
		(regWrStb && regAddr == IPCB_OFF_SYSTEM)
		|=> (fieldCode[10] == $past(regWrData[1:0]))
	) else $error("External line A field missed a write.");

	// CAN bus-off field follows a write to offset 3.
	a_busoff_field_write: assert property ( // R19
		@(posedge clk_sys) disable iff (rst)
		(regWrStb && regAddr == IPCB_OFF_CAN)
		|=> (fieldCode[14] == $past(regWrData[3:2]))
	) else $error("CAN bus-off field missed a write.");

	// Debug transmit-empty field follows a write to offset 1.
	a_tx_field_write: assert property ( // R8
		@(posedge clk_sys) disable iff (rst)
		(regWrStb && regAddr == IPCB_OFF_DEBUG_COMM)
		|=> (fieldCode[3] == $past(regWrData[3:2]))
	) else $error("Transmit-empty field missed a write.");

	// Trace buffer field follows a write to offset 1.
	a_trace_field_write: assert property ( // R9
		@(posedge clk_sys) disable iff (rst)
		(regWrStb && regAddr == IPCB_OFF_DEBUG_COMM)
		|=> (fieldCode[4] == $past(regWrData[1:0]))
	) else $error("Trace buffer field missed a write.");

	// Flash buffers-empty field follows a write to offset 2.
	a_flash_bufs_write: assert property ( // R10
		@(posedge clk_sys) disable iff (rst)
		(regWrStb && regAddr == IPCB_OFF_SYSTEM)
		|=> (fieldCode[5] == $past(regWrData[15:14]))
	) else $error("Flash buffers field missed a write.");

	// Flash command-complete field follows a write to offset 2.
	a_flash_done_write: assert property ( // R11
		@(posedge clk_sys) disable iff (rst)
		(regWrStb && regAddr == IPCB_OFF_SYSTEM)
		|=> (fieldCode[6] == $past(regWrData[13:12]))
	) else $error("Flash done field missed a write.");

	// Flash error field follows a write to offset 2.
	a_flash_fault_write: assert property ( // R12
		@(posedge clk_sys) disable iff (rst)
		(regWrStb && regAddr == IPCB_OFF_SYSTEM)
		|=> (fieldCode[7] == $past(regWrData[11:10]))
	) else $error("Flash error field missed a write.");

	// Low-voltage detector field follows a write to offset 2.
	a_undervolt_write: assert property ( // R14
		@(posedge clk_sys) disable iff (rst)
		(regWrStb && regAddr == IPCB_OFF_SYSTEM)
		|=> (fieldCode[9] == $past(regWrData[7:6]))
	) else $error("Low-voltage field missed a write.");

	// CAN mailbox field follows a write to offset 3.
	a_mailbox_write: assert property ( // R16
		@(posedge clk_sys) disable iff (rst)
		(regWrStb && regAddr == IPCB_OFF_CAN)
		|=> (fieldCode[11] == $past(regWrData[9:8]))
	) else $error("CAN mailbox field missed a write.");

	// CAN wake-up field follows a write to offset 3.
	a_can_wake_write: assert property ( // R17
		@(posedge clk_sys) disable iff (rst)
		(regWrStb && regAddr == IPCB_OFF_CAN)
		|=> (fieldCode[12] == $past(regWrData[7:6]))
	) else $error("CAN wake-up field missed a write.");

	// CAN error field follows a write to offset 3.
	a_can_fault_write: assert property ( // R18
		@(posedge clk_sys) disable iff (rst)
		(regWrStb && regAddr == IPCB_OFF_CAN)
		|=> (fieldCode[13] == $past(regWrData[5:4]))
	) else $error("CAN error field missed a write.");

	// A write to an unmapped offset leaves every register as it was.
	a_unmapped_write_ignored: assert property ( // R1
		@(posedge clk_sys) disable iff (rst)
		(regWrStb && regAddr > IPCB_OFF_CAN)
		|=> $stable({debugEventPriorityA, debugCommPriority, systemEventPriority, canEventPriority})
	) else $error("An unmapped write changed a register.");

	// Without a write strobe no register changes.
	a_fields_hold: assert property (
		@(posedge clk_sys) disable iff (rst)
		!regWrStb
		|=> $stable({debugEventPriorityA, debugCommPriority, systemEventPriority, canEventPriority})
	) else $error("A register changed without a write.");

	// Flash buffers field reads back two cycles after its write.
	a_flash_readback: assert property ( // R10
		@(posedge clk_sys) disable iff (rst)
		(regWrStb && regAddr == IPCB_OFF_SYSTEM)
		##1 (regRdStb && regAddr == IPCB_OFF_SYSTEM && !regWrStb)
		|=> (regRdData[15:14] == $past(regWrData[15:14], 2))
	) else $error("Flash buffers field read back wrong.");

endmodule
`default_nettype wire

/* bench/ipcb_src_model.sv */
// Model of the interrupt sources that feed the priority bank.
// Assumes the sources run on clk_sys and change just after an edge.
`timescale 1ns/10ps
`default_nettype none
module ipcb_src_model
	import ipcb_pkg::*;
(
	input  wire logic                    clk_sys,
	input  wire logic                    rst,
	input  wire logic [IPCB_NUM_SRC-1:0] reqPattern,
	output logic      [IPCB_NUM_SRC-1:0] srcRequest
);

	// Requests are registered so that they always change just after a rising edge.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			srcRequest <= '0;
		end else begin
			srcRequest <= reqPattern;
		end
	end

endmodule
`default_nettype wire

/* bench/tb_irq_priority_config_bank.sv */
// Self-checking bench for the interrupt priority configuration bank.
// Assumes the package constants and a source model on the request inputs.
`timescale 1ns/10ps
`default_nettype none
module tb_irq_priority_config_bank;
	import ipcb_pkg::*;

	logic                      clk_sys = 1'b0;
	logic                      rst = 1'b1;
	logic [IPCB_ADDR_W-1:0]    regAddr = '0;
	logic [IPCB_DATA_W-1:0]    regWrData = '0;
	logic                      regWrStb = 1'b0;
	logic                      regRdStb = 1'b0;
	logic [IPCB_DATA_W-1:0]    regRdData;
	logic [IPCB_NUM_SRC-1:0]   reqPattern = '0;
	logic [IPCB_NUM_SRC-1:0]   srcRequest;
	logic [IPCB_NUM_SRC-1:0]   arbValid;
	logic [2*IPCB_NUM_SRC-1:0] arbLevel;
	int                        mismatches = 0;
	int                        totalChecks = 0;
	int                        cycles = 0;
	logic [15:0]               rdVal;
	logic [15:0]               wrVal;
	logic [15:0]               maskTab [4] = '{IPCB_MASK_DEBUG_EVENT, IPCB_MASK_DEBUG_COMM,
		IPCB_MASK_SYSTEM, IPCB_MASK_CAN};
	int                        srcOff [15] = '{0, 0, 1, 1, 1, 2, 2, 2, 2, 2, 2, 3, 3, 3, 3};
	int                        srcLsb [15] = '{12, 10, 4, 2, 0, 14, 12, 10, 8, 6, 0, 8, 6, 4, 2};

	// The clock toggles every half period of 5 ns.
	always #5 clk_sys = ~clk_sys;

	ipcb_priority_bank DUT (
		.clk_sys    (clk_sys),
		.rst        (rst),
		.regAddr    (regAddr),
		.regWrData  (regWrData),
		.regWrStb   (regWrStb),
		.regRdStb   (regRdStb),
		.regRdData  (regRdData),
		.srcRequest (srcRequest),
		.arbValid   (arbValid),
		.arbLevel   (arbLevel)
	);

	ipcb_src_model sources (
		.clk_sys    (clk_sys),
		.rst        (rst),
		.reqPattern (reqPattern),
		.srcRequest (srcRequest)
	);

	// Prints the counts and the verdict, then ends the run.
	task automatic summarize();
		$display("checks %0d mismatches %0d", totalChecks, mismatches);
		if (mismatches == 0 && totalChecks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Compares one value and reports a difference at once.
	task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
		totalChecks++;
		if (g !== e) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, e, g);
		end
	endtask

	// One-cycle write beside address and data, called just after a rising edge.
	// The strobe stays up when another write follows, so it is never set twice in one step.
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		regWrStb  <= 1'b1;
		regAddr   <= a;
		regWrData <= d;
		@(posedge clk_sys);
	endtask

	// One-cycle read strobe with no gap after a write; data is taken in the following cycle only.
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		regWrStb <= 1'b0;
		regRdStb <= 1'b1;
		regAddr  <= a;
		@(posedge clk_sys);
		regRdStb <= 1'b0;
		#1;
		d = regRdData;
		@(posedge clk_sys);
	endtask

	// Ends any write, sets the source requests and waits until the registered outputs settle.
	task automatic request(input logic [IPCB_NUM_SRC-1:0] p);
		regWrStb   <= 1'b0;
		reqPattern <= p;
		repeat (3) @(posedge clk_sys);
	endtask

	// Cuts a hang short after far more cycles than the tests need.
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			summarize();
		end
	end

	// Main sequence: reset, register map, field codes, field positions.
	initial begin
		repeat (5) @(posedge clk_sys);
		rst <= 1'b0;
		for (int a = 0; a < 4; a++) begin
			rd(a[3:0], rdVal);
			chk("reset value", IPCB_RESET_PRIO, rdVal);
		end
		chk("arbValid after reset", 16'h0000, {1'b0, arbValid});
		for (int a = 0; a < 4; a++) begin
			wr(a[3:0], 16'hFFFF);
			rd(a[3:0], rdVal);
			chk("implemented bits", maskTab[a], rdVal);
		end
		wr(4'h5, 16'hFFFF);
		rd(4'h5, rdVal);
		chk("unmapped read", IPCB_READ_NONE, rdVal);
		// Every code in every field at once, with all sources requesting.
		for (int c = 0; c < 4; c++) begin
			for (int a = 0; a < 4; a++) wr(a[3:0], {8{c[1:0]}});
			request('1);
			chk("arbValid all", (c != 0) ? 16'h7FFF : 16'h0000, {1'b0, arbValid});
			for (int i = 0; i < IPCB_NUM_SRC; i++) begin
				if (c != 0) begin
					chk("arbLevel", (i < IPCB_NUM_DBG) ? 16'(c) : 16'(c - 1), 16'(arbLevel[2*i +: 2]));
				end
			end
			request('0);
			chk("arbValid idle", 16'h0000, {1'b0, arbValid});
		end
		// One field at a time proves each field's position and owner.
		for (int i = 0; i < IPCB_NUM_SRC; i++) begin
			for (int a = 0; a < 4; a++) wr(a[3:0], 16'h0000);
			wrVal = 16'h0003 << srcLsb[i];
			wr(srcOff[i][3:0], wrVal);
			request('1);
			chk("arbValid one", 16'h0001 << i, {1'b0, arbValid});
			chk("arbLevel one", (i < IPCB_NUM_DBG) ? 16'h0003 : 16'h0002, 16'(arbLevel[2*i +: 2]));
			request('0);
		end
		// A reset in mid-run clears fields that software has set.
		wr(4'h2, 16'hFFFF);
		regWrStb <= 1'b0;
		rst      <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		for (int a = 0; a < 4; a++) begin
			rd(a[3:0], rdVal);
			chk("value after reset", IPCB_RESET_PRIO, rdVal);
		end
		summarize();
	end

endmodule
`default_nettype wire
